// [hw/pam_regs.sv]
`timescale 1ns/1ps
`include "pam_cfg.svh"

module pam_regs (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Command port
  input  wire logic              req_valid,
  input  wire pam_pkg::pam_req_t req,
  output logic                   rsp_valid,
  output pam_pkg::pam_rsp_t      rsp,
  // Restore from EEPROM
  input  wire logic              nvm_valid,
  input  wire logic [7:0]        nvm_vendor_mask,
  input  wire logic [7:0]        nvm_fmt,
  // Conversion control
  input  wire logic              conv_enable,
  // Status sources
  input  wire logic [7:0]        other_status,
  input  wire logic [7:0]        vendor_status,
  // Alert gating
  output logic                   alert_req,
  output logic [7:0]             alert_src_other,
  output logic [7:0]             alert_src_vendor,
  // Output-voltage format
  output pam_pkg::pam_fmt_t      fmt,
  output logic                   fmt_linear,
  output logic                   fmt_relative,
  output logic                   fmt_change,
  output pam_pkg::pam_fmt_t      fmt_prev
);

  // Command decode
  wire        is_mask_cmd;
  wire        hit_other;
  wire        hit_vendor;
  wire        hit_fmt;
  wire        hit_any;
  wire        wr_vendor;
  wire        wr_fmt_req;
  wire        fmt_par_ok;
  wire        fmt_open;
  wire        wr_fmt;
  wire        fmt_refused;
  wire [7:0]  vendor_q;
  wire [7:0]  fmt_q;
  wire [7:0]  rd_data;
  wire        rsp_err;
  wire [7:0]  gated_other;
  wire [7:0]  gated_vendor;
  wire        fmt_differs;

  logic                 rsp_valid_ff;
  pam_pkg::pam_rsp_t    rsp_ff;
  pam_pkg::pam_rsp_t    nxt_rsp;
  logic                 alert_ff;
  logic [7:0]           src_other_ff;
  logic [7:0]           src_vendor_ff;
  logic                 fmt_change_ff;
  logic [7:0]           fmt_prev_ff;
  logic [7:0]           nxt_fmt_prev;

  assign is_mask_cmd = (req.code == `PAM_CMD_MASK);
  assign hit_other   = is_mask_cmd && (req.sel == `PAM_SEL_OTHER);
  assign hit_vendor  = is_mask_cmd && (req.sel == `PAM_SEL_VENDOR);
  assign hit_fmt     = (req.code == `PAM_CMD_OUTPUT_VOLTAGE_FORMAT);
  assign hit_any     = hit_other | hit_vendor | hit_fmt;

  assign wr_vendor   = req_valid && req.write && hit_vendor;
  assign wr_fmt_req  = req_valid && req.write && hit_fmt;

  // Signed exponent window, linear mode only
  assign fmt_par_ok  = ($signed(req.data[`PAM_FMT_PAR_HI:0]) >= $signed(`PAM_EXP_MIN)) &&
                       ($signed(req.data[`PAM_FMT_PAR_HI:0]) <= $signed(`PAM_EXP_MAX));
  assign fmt_open    = !conv_enable;
  assign wr_fmt      = wr_fmt_req && fmt_open && fmt_par_ok;
  assign fmt_refused = wr_fmt_req && !wr_fmt;

  pam_mask_reg #(
    .WMASK (`PAM_VENDOR_WMASK),
    .RST   (`PAM_VENDOR_RST)
  ) u_vendor_mask (
    .clk      (clk),
    .rstn     (rstn),
    .load     (nvm_valid),
    .load_val (nvm_vendor_mask),
    .we       (wr_vendor),
    .wdata    (req.data),
    .q        (vendor_q)
  );

  // Mode bits are read-only zero, so only linear format exists
  pam_mask_reg #(
    .WMASK (`PAM_FMT_WMASK),
    .RST   (`PAM_FMT_RST)
  ) u_fmt (
    .clk      (clk),
    .rstn     (rstn),
    .load     (nvm_valid),
    .load_val (nvm_fmt),
    .we       (wr_fmt),
    .wdata    (req.data),
    .q        (fmt_q)
  );

  // Read mux; the other page is a constant
  assign rd_data = hit_other  ? `PAM_OTHER_VAL :
                   hit_vendor ? vendor_q :
                   hit_fmt    ? fmt_q : 8'h00;
  assign rsp_err = !hit_any || fmt_refused;

  always_comb begin
    nxt_rsp      = '0;
    nxt_rsp.err  = rsp_err;
    nxt_rsp.data = req.write ? 8'h00 : rd_data;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff       <= '0;
    end else begin
      rsp_valid_ff <= req_valid;
      rsp_ff       <= req_valid ? nxt_rsp : rsp_ff;
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp       = rsp_ff;

  // Status passes untouched; only the path to the alert line is gated
  assign gated_other  = other_status & ~`PAM_OTHER_VAL;
  assign gated_vendor = vendor_status & ~vendor_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_other_ff  <= 8'h00;
      src_vendor_ff <= 8'h00;
      alert_ff      <= 1'b0;
    end else begin
      src_other_ff  <= gated_other;
      src_vendor_ff <= gated_vendor;
      alert_ff      <= |{gated_other, gated_vendor};
    end
  end

  assign alert_req        = alert_ff;
  assign alert_src_other  = src_other_ff;
  assign alert_src_vendor = src_vendor_ff;

  // Format decode for the voltage command logic
  assign fmt          = pam_pkg::pam_fmt_t'(fmt_q);
  assign fmt_linear   = (fmt.mode == pam_pkg::PAM_MODE_LINEAR);
  assign fmt_relative = fmt.offset_format_select;

  // A host write that changes the format asks the voltage logic to convert its stored values
  assign fmt_differs  = ((req.data & `PAM_FMT_WMASK) != (fmt_q & `PAM_FMT_WMASK));
  assign nxt_fmt_prev = wr_fmt ? fmt_q : fmt_prev_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fmt_change_ff <= 1'b0;
      fmt_prev_ff   <= `PAM_FMT_RST;
    end else begin
      fmt_change_ff <= wr_fmt && fmt_differs;
      fmt_prev_ff   <= nxt_fmt_prev;
    end
  end

  assign fmt_change = fmt_change_ff;
  assign fmt_prev   = pam_pkg::pam_fmt_t'(fmt_prev_ff);

  property p_rsp_next;
    @(posedge clk) disable iff (!rstn)
    req_valid |=> rsp_valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("No answer one cycle after request");

  property p_other_read;
    @(posedge clk) disable iff (!rstn)
    (req_valid && !req.write && hit_other) |=> (rsp.data == 8'h01 && !rsp.err);
  endproperty
  a_other_read: assert property (p_other_read) else $error("Other page read not 01h");

  property p_other_nowrite;
    @(posedge clk) disable iff (!rstn)
    (req_valid && req.write && hit_other && !nvm_valid) |=> $stable(vendor_q);
  endproperty
  a_other_nowrite: assert property (p_other_nowrite) else $error("Other page write hit vendor mask");

  property p_vendor_write;
    @(posedge clk) disable iff (!rstn)
    (wr_vendor && !nvm_valid) |=> (vendor_q == ($past(req.data) & 8'hCE));
  endproperty
  a_vendor_write: assert property (p_vendor_write) else $error("Vendor mask write wrong");

  property p_vendor_ro;
    @(posedge clk) disable iff (!rstn)
    (vendor_q[5] == 1'b0) && (vendor_q[4] == 1'b0) && (vendor_q[0] == 1'b0);
  endproperty
  a_vendor_ro: assert property (p_vendor_ro) else $error("Vendor read-only bit set");

  property p_gate;
    @(posedge clk) disable iff (!rstn)
    ##1 ((alert_src_vendor & $past(vendor_q)) == 8'h00) && !alert_src_other[0];
  endproperty
  a_gate: assert property (p_gate) else $error("Masked source reached alert");

  property p_unmasked_alert;
    @(posedge clk) disable iff (!rstn)
    (vendor_status[6] && !vendor_q[6]) || (vendor_status[1] && !vendor_q[1]) |=> alert_req;
  endproperty
  a_unmasked_alert: assert property (p_unmasked_alert) else $error("Unmasked source lost");

  property p_fmt_locked;
    @(posedge clk) disable iff (!rstn)
    (wr_fmt_req && conv_enable && !nvm_valid) |=> ($stable(fmt_q) && rsp.err);
  endproperty
  a_fmt_locked: assert property (p_fmt_locked) else $error("Format written during conversion");

  property p_fmt_range;
    @(posedge clk) disable iff (!rstn)
    (wr_fmt_req && !conv_enable && !nvm_valid &&
     ($signed(req.data[4:0]) > -5'sd4 || $signed(req.data[4:0]) < -5'sd12))
    |=> ($stable(fmt_q) && rsp.err);
  endproperty
  a_fmt_range: assert property (p_fmt_range) else $error("Exponent outside -4..-12 taken");

  property p_mode_linear;
    @(posedge clk) disable iff (!rstn)
    fmt_linear && (fmt_q[6:5] == 2'b00) && (fmt_relative == fmt_q[7]);
  endproperty
  a_mode_linear: assert property (p_mode_linear) else $error("Mode code not linear");

  property p_fmt_change;
    @(posedge clk) disable iff (!rstn)
    (wr_fmt && fmt_differs && !nvm_valid) |=> (fmt_change && fmt_prev_ff == $past(fmt_q))
                                              ##1 (fmt_change == $past(wr_fmt && fmt_differs));
  endproperty
  a_fmt_change: assert property (p_fmt_change) else $error("Format change not signalled");

  property p_fmt_read;
    @(posedge clk) disable iff (!rstn)
    (req_valid && !req.write && hit_fmt) |=> (rsp.data == $past(fmt_q));
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("Format read mismatch");

endmodule : pam_regs

// [hw/pam_cfg.svh]
`ifndef PAM_CFG_SVH
`define PAM_CFG_SVH

`define PAM_CMD_MASK      8'h1B
`define PAM_CMD_OUTPUT_VOLTAGE_FORMAT 8'h20
`define PAM_SEL_OTHER     8'h7F
`define PAM_SEL_VENDOR    8'h80
`define PAM_OTHER_VAL     8'h01
`define PAM_VENDOR_WMASK  8'hCE
`define PAM_VENDOR_RST    8'hCE
`define PAM_FMT_WMASK     8'h9F
`define PAM_FMT_RST       8'h17
`define PAM_FMT_REL_BIT   7
`define PAM_FMT_MODE_HI   6
`define PAM_FMT_MODE_LO   5
`define PAM_FMT_PAR_HI    4
`define PAM_BIT_SELF      6
`define PAM_BIT_SYNC      1
`define PAM_EXP_MIN       5'h14
`define PAM_EXP_MAX       5'h1C

`endif

// [hw/pam_pkg.sv]
package pam_pkg;

  typedef enum logic [1:0] {
    PAM_MODE_LINEAR = 2'b00,
    PAM_MODE_HALF   = 2'b01,
    PAM_MODE_VID    = 2'b10,
    PAM_MODE_DIRECT = 2'b11
  } pam_mode_t;

  typedef struct packed {
    logic       write;
    logic [7:0] code;
    logic [7:0] sel;
    logic [7:0] data;
  } pam_req_t;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } pam_rsp_t;

  typedef struct packed {
    logic       offset_format_select;
    pam_mode_t  mode;
    logic [4:0] param;
  } pam_fmt_t;

endpackage : pam_pkg

// [hw/pam_mask_reg.sv]
`timescale 1ns/1ps
`include "pam_cfg.svh"

module pam_mask_reg #(
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] RST   = 8'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Restore from non-volatile copy
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  // Host write
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  // Contents
  output logic [7:0]      q
);

  logic [7:0] val_ff;
  logic [7:0] nxt_val;
  wire  [7:0] src;
  wire        upd;

  assign upd     = load | we;
  assign src     = load ? load_val : wdata;
  // Read-only bits keep their fixed value on any update
  assign nxt_val = upd ? ((src & WMASK) | (val_ff & ~WMASK)) : val_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      val_ff <= RST;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;

  property p_ro_fixed;
    @(posedge clk) disable iff (!rstn)
    ((q & ~WMASK) == (RST & ~WMASK));
  endproperty
  a_ro_fixed: assert property (p_ro_fixed) else $error("Read-only bits moved");

  property p_upd_now;
    @(posedge clk) disable iff (!rstn)
    upd |=> ((q & WMASK) == ($past(src) & WMASK));
  endproperty
  a_upd_now: assert property (p_upd_now) else $error("Update not seen next cycle");

endmodule : pam_mask_reg

// [testbench/pam_host.sv]
`timescale 1ns/1ps

module pam_host (
  // Clock
  input  wire logic              clk,
  // Command port
  output logic                   req_valid,
  output pam_pkg::pam_req_t      req,
  input  wire logic              rsp_valid,
  input  wire pam_pkg::pam_rsp_t rsp
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Released request fields show the inverse so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] sel,
                      input logic [7:0] data, output pam_pkg::pam_rsp_t r);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{write: w, code: code, sel: sel, data: data};
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~req;
    #1;
    r = rsp_valid ? rsp : 'x;
  endtask : xfer
endmodule : pam_host

// [testbench/pam_regs_tb.sv]
`timescale 1ns/1ps

module pam_regs_tb;
  logic              clk, rstn, req_valid, rsp_valid, nvm_valid, conv_enable;
  logic              alert_req, fmt_linear, fmt_relative, fmt_change;
  logic [7:0]        nvm_vendor_mask, nvm_fmt, other_status, vendor_status;
  logic [7:0]        alert_src_other, alert_src_vendor;
  pam_pkg::pam_req_t req;
  pam_pkg::pam_rsp_t rsp, r;
  pam_pkg::pam_fmt_t fmt, fmt_prev;
  int                failures, n_tests;

  pam_regs u_pam_regs (.clk, .rstn, .req_valid, .req, .rsp_valid, .rsp, .nvm_valid,
    .nvm_vendor_mask, .nvm_fmt, .conv_enable, .other_status, .vendor_status, .alert_req,
    .alert_src_other, .alert_src_vendor, .fmt, .fmt_linear, .fmt_relative, .fmt_change, .fmt_prev);

  pam_host u_pam_host (.clk, .req_valid, .req, .rsp_valid, .rsp);

  task automatic close_out;
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] code, input logic [7:0] sel, input logic [7:0] exp);
    u_pam_host.xfer(1'b0, code, sel, 8'h00, r);
    chk(r, {1'b0, exp});
  endtask : rd

  task automatic wr(input logic [7:0] code, input logic [7:0] sel, input logic [7:0] d, input logic e);
    u_pam_host.xfer(1'b1, code, sel, d, r);
    chk(r, {e, 8'h00});
  endtask : wr

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic t_reset;
    rd(8'h1B, 8'h7F, 8'h01);
    rd(8'h1B, 8'h80, 8'hCE);
    rd(8'h20, 8'h00, 8'h17);
    chk({1'b0, fmt_prev}, 9'h017);
  endtask : t_reset

  task automatic t_other;
    wr(8'h1B, 8'h7F, 8'hFE, 1'b0);
    rd(8'h1B, 8'h7F, 8'h01);
    wr(8'h1B, 8'h81, 8'h00, 1'b1);
    @(posedge clk);
    other_status <= 8'hFF;
    tick;
    chk({1'b0, alert_src_other}, 9'h0FE);
    chk({8'h00, alert_req}, 9'h001);
    other_status <= 8'h00;
  endtask : t_other

  task automatic t_vendor;
    wr(8'h1B, 8'h80, 8'hFF, 1'b0);
    rd(8'h1B, 8'h80, 8'hCE);
    wr(8'h1B, 8'h80, 8'h00, 1'b0);
    rd(8'h1B, 8'h80, 8'h00);
    @(posedge clk);
    vendor_status <= 8'hCE;
    tick;
    chk({1'b0, alert_src_vendor}, 9'h0CE);
    chk({8'h00, alert_req}, 9'h001);
    wr(8'h1B, 8'h80, 8'h40, 1'b0);
    tick;
    chk({1'b0, alert_src_vendor}, 9'h08E);
    wr(8'h1B, 8'h80, 8'hCE, 1'b0);
    tick;
    chk({alert_req, alert_src_vendor}, 9'h000);
    vendor_status <= 8'h00;
  endtask : t_vendor

  task automatic t_fmt;
    @(posedge clk);
    conv_enable <= 1'b1;
    wr(8'h20, 8'h00, 8'h94, 1'b1);
    rd(8'h20, 8'h00, 8'h17);
    conv_enable <= 1'b0;
    wr(8'h20, 8'h00, 8'h94, 1'b0);
    chk({7'h00, fmt_change, fmt_relative}, 9'h003);
    chk({1'b0, fmt_prev}, 9'h017);
    chk({1'b0, fmt}, 9'h094);
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 8'h00, {1'b0, 2'(i), 5'h18}, 1'b0);
      rd(8'h20, 8'h00, 8'h18);
      chk({8'h00, fmt_linear}, 9'h001);
    end
    wr(8'h20, 8'h00, 8'h13, 1'b1);
    wr(8'h20, 8'h00, 8'h1D, 1'b1);
    wr(8'h20, 8'h00, 8'h14, 1'b0);
    wr(8'h20, 8'h00, 8'h1C, 1'b0);
    wr(8'h20, 8'h00, 8'h1C, 1'b0);
    chk({8'h00, fmt_change}, 9'h000);
    rd(8'h20, 8'h00, 8'h1C);
    wr(8'h21, 8'h00, 8'h00, 1'b1);
  endtask : t_fmt

  task automatic t_nvm;
    @(posedge clk);
    nvm_vendor_mask <= 8'hFF;
    nvm_fmt         <= 8'hFF;
    nvm_valid       <= 1'b1;
    @(posedge clk);
    nvm_valid <= 1'b0;
    rd(8'h1B, 8'h80, 8'hCE);
    rd(8'h20, 8'h00, 8'h9F);
  endtask : t_nvm

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rstn            = 1'b0;
    nvm_valid       = 1'b0;
    nvm_vendor_mask = 8'h00;
    nvm_fmt         = 8'h00;
    conv_enable     = 1'b0;
    other_status    = 8'h00;
    vendor_status   = 8'h00;
    failures        = 0;
    n_tests         = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_other;
    t_vendor;
    t_fmt;
    t_nvm;
    close_out;
  end

  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    close_out;
  end
endmodule : pam_regs_tb
